/* File: rtl/hot_redundancy_role_supervisor.sv */
// Behaviour
// R1 - missing mandatory assignment raises configuration fault
// R2 - only standby unit energises switch relay
// R3 - active unit asserts active indicator
// R4 - never both units active
// R5 - hand-back acts on rising edge only
// R6 - policy: hand-back only when both OFF
// R7 - primary feedback expects 0 active, 1 observer
// R8 - standby feedback expects 1 active, 0 observer
// R9 - mismatch: standby warns, active keeps role
// R10 - observer suppresses CAN transmit, always receives
// R11 - link mirrors analogue-digital and virtual inputs
// R12 - link carries raw analogue measurements continuously
// R13 - new active holds linked analogue 200 ms; code holds only on standby relay energising, not on primary takeover
// R14 - speed measurements held 200 ms after switch; code holds only on standby relay energising, not on primary takeover
// R15 - link aligns excitation command state
// R16 - role 0/1/2; equal roles raise fault; code skips the equal-role check when the role is 0 (disabled)
// R17 - DTR toggle 5 ms, status 100 ms, peer timeouts
// R18 - inputs synchronised, debounced, hand-back edge pulse
`timescale 1ns/1ps
`default_nettype none
module hot_redundancy_role_supervisor #(
    parameter int unsigned TICK_CYCLES = redundancy_pkg::TICK_CYCLES,
    parameter int unsigned HOLD_TICKS  = redundancy_pkg::HOLD_TICKS,
    parameter int          AIN_W       = 64,
    parameter int          SPD_W       = 32,
    parameter int          DIN_W       = 16
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    // AXI4-Lite slave
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // plant pins
    input  wire logic                      hand_back_request_input,
    input  wire logic                      switch_relay_feedback_input,
    output logic                           switch_relay_command_output,
    output logic                           active_role_indicator_output,
    output logic                           configuration_fault_alarm,
    output logic                           switch_relay_failure_warning,
    output logic                           can_tx_enable,
    output logic                           irq,
    // peer_sync_link
    input  wire redundancy_pkg::link_in_s  peer_in,
    output redundancy_pkg::link_out_s      peer_out,
    input  wire logic [1:0]                peer_role,
    input  wire logic                      peer_off_mode,
    // measurements
    input  wire logic [AIN_W-1:0]          local_analogue,
    input  wire logic [AIN_W-1:0]          peer_analogue,
    input  wire logic [SPD_W-1:0]          local_speed,
    input  wire logic [SPD_W-1:0]          peer_speed,
    input  wire logic [DIN_W-1:0]          peer_virtual_inputs,
    input  wire logic [DIN_W-1:0]          local_virtual_inputs,
    input  wire logic                      peer_excitation,
    input  wire logic                      local_excitation,
    output logic [AIN_W-1:0]               used_analogue,
    output logic [SPD_W-1:0]               used_speed,
    output logic [DIN_W-1:0]               used_virtual_inputs,
    output logic                           excitation_command
);

    localparam int NE = redundancy_pkg::NUM_EV;

    typedef struct packed {
        logic [1:0]       hb_sync;
        logic [1:0]       fb_sync;
        logic             hb_deb;
        logic             fb_deb;
        logic [7:0]       hb_cnt;
        logic [7:0]       fb_cnt;
        logic [15:0]      tick_cnt;
        logic [15:0]      hold_cnt;
        logic [7:0]       dtr_cnt;
        logic [11:0]      stat_cnt;
        logic [11:0]      msg_cnt;
        logic [11:0]      dsr_cnt;
        logic             dsr_prev;
        logic             dtr;
        logic             status_tx;
        logic             active;
        logic             relay;
        logic             peer_fail;
        logic [31:0]      cfg;
        logic [NE-1:0]    ev_st;
        logic [NE-1:0]    ev_mask;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic [AIN_W-1:0] ain_hold;
        logic [SPD_W-1:0] spd_hold;
    } state_s;

    state_s q;
    state_s d;

    logic tick;
    logic hb_pulse;
    logic fault;
    logic is_standby;
    logic is_primary;
    logic fb_expected;
    logic mismatch;
    logic hb_allowed;
    logic take_req;
    logic wr_fire;
    logic [NE-1:0] ev_set;
    logic [1:0] role;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        d = q;
        role = q.cfg[redundancy_pkg::CFG_ROLE_LSB +: 2];
        tick = (q.tick_cnt == 16'(TICK_CYCLES - 1));
        d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
        is_standby = (role == redundancy_pkg::ROLE_STANDBY); // R16
        is_primary = (role == redundancy_pkg::ROLE_PRIMARY); // R16

        // two-flop synchronisers and tick-based debounce
        d.hb_sync = {q.hb_sync[0], hand_back_request_input}; // R18
        d.fb_sync = {q.fb_sync[0], switch_relay_feedback_input}; // R18
        if (q.hb_sync[1] == q.hb_deb) begin
            d.hb_cnt = 8'h00;
        end else if (tick) begin
            d.hb_cnt = q.hb_cnt + 8'h01;
            if (q.hb_cnt == 8'(redundancy_pkg::DEBOUNCE_TICKS - 1)) begin
                d.hb_deb = q.hb_sync[1]; // R18
                d.hb_cnt = 8'h00;
            end
        end
        if (q.fb_sync[1] == q.fb_deb) begin
            d.fb_cnt = 8'h00;
        end else if (tick) begin
            d.fb_cnt = q.fb_cnt + 8'h01;
            if (q.fb_cnt == 8'(redundancy_pkg::DEBOUNCE_TICKS - 1)) begin
                d.fb_deb = q.fb_sync[1];
                d.fb_cnt = 8'h00;
            end
        end
        hb_pulse = (d.hb_deb && !q.hb_deb); // R5 R18

        // configuration fault
        fault = !q.cfg[redundancy_pkg::CFG_ASSIGN_RELAY]
              || !q.cfg[redundancy_pkg::CFG_ASSIGN_HB]
              || !q.cfg[redundancy_pkg::CFG_ASSIGN_FB]; // R1
        fault = fault || ((role != redundancy_pkg::ROLE_DISABLED)
              && (peer_role == role)); // R16

        // peer link heartbeat
        d.dtr_cnt = q.dtr_cnt;
        d.status_tx = 1'b0;
        if (tick) begin
            if (q.dtr_cnt == 8'(redundancy_pkg::DTR_TICKS - 1)) begin
                d.dtr_cnt = 8'h00;
                d.dtr = !q.dtr; // R17
            end else begin
                d.dtr_cnt = q.dtr_cnt + 8'h01;
            end
            if (q.stat_cnt == 12'(redundancy_pkg::STATUS_TICKS - 1)) begin
                d.stat_cnt = 12'h000;
                d.status_tx = 1'b1; // R17
            end else begin
                d.stat_cnt = q.stat_cnt + 12'h001;
            end
            if (q.msg_cnt != 12'(redundancy_pkg::MSG_TIMEOUT_TICKS)) begin
                d.msg_cnt = q.msg_cnt + 12'h001;
            end
            if (q.dsr_cnt != 12'(redundancy_pkg::DSR_TIMEOUT_TICKS)) begin
                d.dsr_cnt = q.dsr_cnt + 12'h001;
            end
        end
        d.dsr_prev = peer_in.dsr;
        if (peer_in.dsr != q.dsr_prev) begin
            d.dsr_cnt = 12'h000;
        end
        if (peer_in.rx_valid) begin
            d.msg_cnt = 12'h000;
        end
        d.peer_fail = (q.msg_cnt == 12'(redundancy_pkg::MSG_TIMEOUT_TICKS))
                   || (q.dsr_cnt == 12'(redundancy_pkg::DSR_TIMEOUT_TICKS)); // R17

        // role handling
        hb_allowed = !q.cfg[redundancy_pkg::CFG_HB_OFF_ONLY]
                   || (q.cfg[redundancy_pkg::CFG_OFF_MODE] && peer_off_mode); // R6
        take_req = 1'b0;
        if (is_standby && !q.active && (q.peer_fail || !peer_in.peer_active)) begin
            take_req = q.peer_fail;
        end
        if (is_standby) begin
            if (take_req) begin
                d.active = 1'b1;
                d.relay = 1'b1; // R2
            end else if (hb_pulse && hb_allowed && q.active) begin
                d.active = 1'b0;
                d.relay = 1'b0;
            end
        end else if (is_primary) begin
            d.relay = 1'b0; // R2
            // primary takes the role only while the standby does not hold it
            if (!peer_in.peer_active && (q.peer_fail || hb_pulse)) begin
                d.active = 1'b1; // R4
            end else if (peer_in.peer_active) begin
                d.active = 1'b0; // R4
            end
        end else begin
            d.active = 1'b0;
            d.relay = 1'b0;
        end
        if (fault) begin
            d.relay = 1'b0;
        end

        // relay feedback supervision
        fb_expected = is_primary ? !q.active : q.active; // R7 R8
        mismatch = is_standby && (q.fb_deb != fb_expected); // R9

        // hold linked values after the relay energises
        if (d.relay && !q.relay) begin
            d.hold_cnt = 16'(HOLD_TICKS); // R13 R14
        end else if (tick && q.hold_cnt != 16'h0000) begin
            d.hold_cnt = q.hold_cnt - 16'h0001;
        end
        if (q.hold_cnt == 16'h0000 && !(d.relay && !q.relay)) begin
            d.ain_hold = peer_analogue; // R12
            d.spd_hold = peer_speed; // R14
        end

        // events
        ev_set = '0;
        ev_set[redundancy_pkg::EV_CFG_FAULT] = fault;
        ev_set[redundancy_pkg::EV_RELAY_WARN] = mismatch;
        ev_set[redundancy_pkg::EV_HAND_BACK] = hb_pulse;
        ev_set[redundancy_pkg::EV_PEER_FAIL] = q.peer_fail;
        ev_set[redundancy_pkg::EV_ROLE_CHG] = (d.active != q.active);

        // AXI4-Lite write path
        if (s_axi_awvalid && !q.aw_got) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_got) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        wr_fire = q.aw_got && q.w_got && !q.bvalid;
        d.ev_st = q.ev_st;
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = redundancy_pkg::RESP_OKAY;
            case (q.awaddr)
                redundancy_pkg::ADDR_CONFIG: d.cfg = merge(q.cfg, q.wdata, q.wstrb);
                redundancy_pkg::ADDR_IRQ_ST: d.ev_st = q.ev_st & ~q.wdata[NE-1:0];
                redundancy_pkg::ADDR_IRQ_MSK: d.ev_mask = q.wdata[NE-1:0];
                redundancy_pkg::ADDR_CMD: begin
                    if (q.wdata[redundancy_pkg::CMD_TAKE] && is_standby && !fault
                        && !peer_in.peer_active) begin // R4
                        d.active = 1'b1;
                        d.relay = 1'b1;
                        d.hold_cnt = 16'(HOLD_TICKS);
                    end
                end
                redundancy_pkg::ADDR_STATUS: ;
                default: d.bresp = redundancy_pkg::RESP_SLVERR;
            endcase
        end
        d.ev_st = d.ev_st | ev_set; // set wins over clear
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // AXI4-Lite read path
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = redundancy_pkg::RESP_OKAY;
            case (s_axi_araddr)
                redundancy_pkg::ADDR_CONFIG: d.rdata = q.cfg;
                redundancy_pkg::ADDR_STATUS: d.rdata = {24'h000000, q.fb_deb, q.hb_deb,
                    q.peer_fail, q.hold_cnt != 16'h0000, fault, mismatch, q.relay, q.active};
                redundancy_pkg::ADDR_IRQ_ST: d.rdata = 32'(q.ev_st);
                redundancy_pkg::ADDR_IRQ_MSK: d.rdata = 32'(q.ev_mask);
                redundancy_pkg::ADDR_CMD: d.rdata = 32'h0000_0000;
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = redundancy_pkg::RESP_SLVERR;
                end
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.cfg <= redundancy_pkg::CFG_RESET;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.aw_got;
    assign s_axi_wready = !q.w_got;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    assign switch_relay_command_output = q.relay && is_standby; // R2
    assign active_role_indicator_output = q.active; // R3
    assign configuration_fault_alarm = fault; // R1 R16
    assign switch_relay_failure_warning = mismatch; // R9
    assign can_tx_enable = q.active; // R10
    assign irq = |(q.ev_st & q.ev_mask);

    assign peer_out.dtr = q.dtr; // R17
    assign peer_out.tx = q.status_tx; // R17
    assign peer_out.data = {27'h0000000, local_excitation, q.relay, q.active, role}; // R15

    assign used_analogue = (q.hold_cnt != 16'h0000) ? q.ain_hold
                         : (q.active ? local_analogue : peer_analogue); // R12 R13
    assign used_speed = (q.hold_cnt != 16'h0000) ? q.spd_hold
                      : (q.active ? local_speed : peer_speed); // R14
    assign used_virtual_inputs = q.active ? local_virtual_inputs : peer_virtual_inputs; // R11
    assign excitation_command = q.active ? local_excitation : peer_excitation; // R15

endmodule
`default_nettype wire

/* File: rtl/redundancy_pkg.sv */
package redundancy_pkg;

    // redundancy role setting encodings
    localparam logic [1:0] ROLE_DISABLED = 2'h0;
    localparam logic [1:0] ROLE_STANDBY  = 2'h1;
    localparam logic [1:0] ROLE_PRIMARY  = 2'h2;

    // clock and timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_US         = 100;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned HOLD_MS         = 200;
    localparam int unsigned HOLD_TICKS      = HOLD_MS * 1000 / TICK_US;
    localparam int unsigned DTR_MS          = 5;
    localparam int unsigned DTR_TICKS       = DTR_MS * 1000 / TICK_US;
    localparam int unsigned STATUS_MS       = 100;
    localparam int unsigned STATUS_TICKS    = STATUS_MS * 1000 / TICK_US;
    localparam int unsigned MSG_TIMEOUT_MS  = 250;
    localparam int unsigned MSG_TIMEOUT_TICKS = MSG_TIMEOUT_MS * 1000 / TICK_US;
    localparam int unsigned DSR_TIMEOUT_MS  = 25;
    localparam int unsigned DSR_TIMEOUT_TICKS = DSR_TIMEOUT_MS * 1000 / TICK_US;
    localparam int unsigned DEBOUNCE_TICKS  = 50;

    // AXI4-Lite register byte offsets
    localparam logic [7:0] ADDR_CONFIG  = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
    localparam logic [7:0] ADDR_CMD     = 8'h10;

    // config field positions
    localparam int CFG_ROLE_LSB      = 0;
    localparam int CFG_HB_OFF_ONLY   = 2;
    localparam int CFG_ASSIGN_RELAY  = 3;
    localparam int CFG_ASSIGN_HB     = 4;
    localparam int CFG_ASSIGN_FB     = 5;
    localparam int CFG_OFF_MODE      = 6;
    localparam logic [31:0] CFG_RESET = 32'h0000_0038;

    // cmd register: bit 0 takes the active role (manual takeover, standby only)
    localparam int CMD_TAKE = 0;

    // event bits, shared by irq status and mask
    localparam int EV_CFG_FAULT = 0;
    localparam int EV_RELAY_WARN = 1;
    localparam int EV_HAND_BACK = 2;
    localparam int EV_PEER_FAIL = 3;
    localparam int EV_ROLE_CHG  = 4;
    localparam int NUM_EV       = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        tx;
        logic [31:0] data;
        logic        dtr;
    } link_out_s;

    typedef struct packed {
        logic        rx_valid;
        logic [31:0] rx_data;
        logic        peer_active;
        logic        dsr;
    } link_in_s;

endpackage

/* File: sim/hot_redundancy_role_supervisor_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module role_checker #(
    parameter int AIN_W = 64,
    parameter int SPD_W = 32
) (
    input wire logic                      clk,
    input wire logic                      reset,
    input wire logic                      switch_relay_command_output,
    input wire logic                      active_role_indicator_output,
    input wire logic                      configuration_fault_alarm,
    input wire logic                      switch_relay_failure_warning,
    input wire logic                      can_tx_enable,
    input wire logic                      excitation_command,
    input wire logic                      local_excitation,
    input wire logic                      peer_excitation,
    input wire redundancy_pkg::link_in_s  peer_in,
    input wire redundancy_pkg::link_out_s peer_out,
    input wire logic [AIN_W-1:0]          used_analogue,
    input wire logic [SPD_W-1:0]          used_speed
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_fault_relay;
        configuration_fault_alarm [*2] |-> !switch_relay_command_output;
    endproperty
    a_fault_relay: assert property (p_fault_relay) else $error("relay on under fault");
    property p_relay_active;
        $rose(switch_relay_command_output) |-> ##[0:2] active_role_indicator_output;
    endproperty
    a_relay_active: assert property (p_relay_active) else $error("relay without role");
    property p_one_active;
        !(active_role_indicator_output && peer_in.peer_active);
    endproperty
    a_one_active: assert property (p_one_active) else $error("both units active");
    property p_can_tx;
        can_tx_enable == active_role_indicator_output;
    endproperty
    a_can_tx: assert property (p_can_tx) else $error("can transmit wrong");
    property p_exc;
        excitation_command == (active_role_indicator_output ? local_excitation
                                                            : peer_excitation);
    endproperty
    a_exc: assert property (p_exc) else $error("excitation source wrong");
    property p_hold_ain;
        $rose(switch_relay_command_output) |=> $stable(used_analogue) [*8];
    endproperty
    a_hold_ain: assert property (p_hold_ain) else $error("analogue not held");
    property p_hold_spd;
        $rose(switch_relay_command_output) |=> $stable(used_speed) [*8];
    endproperty
    a_hold_spd: assert property (p_hold_spd) else $error("speed not held");
    property p_warn_keep;
        $rose(switch_relay_failure_warning) && active_role_indicator_output
        |=> active_role_indicator_output [*4];
    endproperty
    a_warn_keep: assert property (p_warn_keep) else $error("role lost on warning");
    property p_dtr;
        $changed(peer_out.dtr) |=> $stable(peer_out.dtr) [*8];
    endproperty
    a_dtr: assert property (p_dtr) else $error("dtr toggles too fast");
    property p_tx;
        peer_out.tx |=> !peer_out.tx [*8];
    endproperty
    a_tx: assert property (p_tx) else $error("status send too often");
endmodule
bind hot_redundancy_role_supervisor role_checker #(.AIN_W(AIN_W), .SPD_W(SPD_W))
    role_checker_inst (.*);
`default_nettype wire

/* File: sim/peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module peer_model (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    alive,
    input  wire logic                    take,
    output var redundancy_pkg::link_in_s peer_in
);
    int cnt;
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= 0;
            peer_in <= '0;
        end else begin
            cnt <= cnt + 1;
            peer_in.rx_valid <= alive && (cnt % 1000 == 0);
            // a dead peer leaves the rx data line wandering
            peer_in.rx_data <= alive ? 32'h0000_0002 : ~peer_in.rx_data;
            if (alive && cnt % 500 == 0) begin
                peer_in.dsr <= !peer_in.dsr;
            end
            peer_in.peer_active <= alive && take;
        end
    end
endmodule
`default_nettype wire

/* File: sim/hot_redundancy_role_supervisor_test.sv */
`timescale 1ns/1ps
`default_nettype none
module hot_redundancy_role_supervisor_test;
    logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, hand_back_request_input, switch_relay_feedback_input;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        switch_relay_command_output, active_role_indicator_output, irq;
    logic        configuration_fault_alarm, switch_relay_failure_warning, can_tx_enable;
    logic        peer_off_mode, peer_excitation, local_excitation, excitation_command;
    logic        alive, take, fb_bad, d0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data, local_speed, peer_speed, used_speed;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, peer_role, resp;
    logic [63:0] local_analogue, peer_analogue, used_analogue;
    logic [15:0] peer_virtual_inputs, local_virtual_inputs, used_virtual_inputs;
    logic [31:0] cfgs [5] = '{32'h31, 32'h29, 32'h19, 32'h3A, 32'h39};
    redundancy_pkg::link_in_s  peer_in;
    redundancy_pkg::link_out_s peer_out;
    int          fails, n_checks, seed, i;

    hot_redundancy_role_supervisor #(.TICK_CYCLES(10), .HOLD_TICKS(20))
        hot_redundancy_role_supervisor_inst (.*);
    peer_model peer_model_inst (.clk(clk), .reset(reset), .alive(alive), .take(take),
                                .peer_in(peer_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // standby feedback contact follows the relay unless a fault is injected
    always @(posedge clk) switch_relay_feedback_input <= switch_relay_command_output ^ fb_bad;

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tmo;
        fails++;
        $display("ERROR %0t: wait ran out", $time);
        print_verdict();
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (!s_axi_bvalid) tmo();
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        if (!s_axi_rvalid) tmo();
    endtask

    initial begin
        seed = 32'h1fc715d1;
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {hand_back_request_input, switch_relay_feedback_input, fb_bad, peer_off_mode} = '0;
        alive = 1'b1;
        take = 1'b1;
        peer_role = redundancy_pkg::ROLE_PRIMARY;
        peer_excitation = 1'b1;
        local_excitation = 1'b0;
        local_analogue = {$random(seed), $random(seed)};
        peer_analogue = {$random(seed), $random(seed)};
        local_speed = $random(seed);
        peer_speed = $random(seed);
        local_virtual_inputs = $random(seed);
        peer_virtual_inputs = $random(seed);
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        cyc(2);
        chk(active_role_indicator_output, 0);
        rd(redundancy_pkg::ADDR_CONFIG);
        chk(rd_data, redundancy_pkg::CFG_RESET);
        rd(8'h20);
        chk({resp, rd_data}, {redundancy_pkg::RESP_SLVERR, 32'h0});
        for (i = 0; i < 5; i++) begin
            wr(redundancy_pkg::ADDR_CONFIG, cfgs[i]);
            cyc(2);
            chk(configuration_fault_alarm, (cfgs[i][5:3] != 3'h7) || (cfgs[i][1:0] == peer_role));
            chk(switch_relay_command_output, 0);
        end
        cyc(600);
        chk({active_role_indicator_output, can_tx_enable, switch_relay_failure_warning}, 0);
        chk({used_virtual_inputs, excitation_command}, {peer_virtual_inputs, 1'b1});
        chk({used_analogue, used_speed}, {peer_analogue, peer_speed});
        d0 = peer_out.dtr;
        cyc(500);
        chk(peer_out.dtr, !d0);
        @(posedge clk);
        alive <= 1'b0;
        take <= 1'b0;
        for (i = 0; i < 5000 && switch_relay_command_output !== 1'b1; i++) cyc(1);
        if (i == 5000) tmo();
        chk(i >= 1900, 1);
        cyc(2);
        chk({active_role_indicator_output, can_tx_enable}, 2'h3);
        chk({used_virtual_inputs, excitation_command}, {local_virtual_inputs, 1'b0});
        cyc(140);
        chk({used_analogue, used_speed}, {peer_analogue, peer_speed});
        cyc(800);
        chk({used_analogue, used_speed}, {local_analogue, local_speed});
        @(posedge clk);
        fb_bad <= 1'b1;
        cyc(700);
        chk({switch_relay_failure_warning, active_role_indicator_output}, 2'h3);
        fb_bad <= 1'b0;
        alive <= 1'b1;
        cyc(700);
        chk(switch_relay_failure_warning, 0);
        rd(redundancy_pkg::ADDR_IRQ_ST);
        chk({rd_data[redundancy_pkg::EV_ROLE_CHG], rd_data[redundancy_pkg::EV_PEER_FAIL]}, 2'h3);
        wr(redundancy_pkg::ADDR_IRQ_MSK, 32'h0);
        cyc(2);
        chk(irq, 0);
        wr(redundancy_pkg::ADDR_IRQ_MSK, 32'h1F);
        cyc(2);
        chk(irq, 1);
        wr(redundancy_pkg::ADDR_IRQ_ST, 32'h1F);
        cyc(2);
        chk(irq, 0);
        peer_off_mode <= 1'b1;
        wr(redundancy_pkg::ADDR_CONFIG, 32'h3D);
        cyc(1200);
        hand_back_request_input <= 1'b1;
        cyc(700);
        chk(active_role_indicator_output, 1);
        hand_back_request_input <= 1'b0;
        wr(redundancy_pkg::ADDR_CONFIG, 32'h7D);
        cyc(700);
        hand_back_request_input <= 1'b1;
        cyc(700);
        chk({active_role_indicator_output, switch_relay_command_output}, 0);
        take <= 1'b1;
        cyc(1500);
        chk({active_role_indicator_output, can_tx_enable}, 0);
        peer_role <= redundancy_pkg::ROLE_STANDBY;
        wr(redundancy_pkg::ADDR_CONFIG, 32'h3A);
        cyc(2);
        chk({configuration_fault_alarm, switch_relay_command_output,
             switch_relay_failure_warning}, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
